// ---- logic/t5ar_top.sv ----
// Auto-reload timer with 16-bit and split 8-bit modes, AXI4-Lite slave.
// Assumes one clock, synchronous reset, and a master that keeps
// valid and payload steady until each channel is taken.
`timescale 1ns/1ps
`include "t5ar_defines.svh"

// How it works
// - Count is two bytes; runs as one 16-bit or two 8-bit reloaders.
// - Ticks come from system clock, clock over 12, or synced ext over 8.
// - In 16-bit mode a rollover of all ones loads both reload bytes.
// - Each 16-bit rollover sets the high overflow flag, control bit 7.
// - Timer interrupt enable makes every 16-bit overflow request interrupt.
// - With low enable too, low byte rollover also requests interrupt.
// - Split set and auxiliary bit clear give two separate 8-bit timers.
// - In split mode each byte reloads from its own reload register.
// - In split mode run gates the high byte only; low always counts.
// - Run bit, control bit 2, starts the 16-bit count or split high byte at one, stops it at zero.
// - Per byte in split mode, low select for the 16-bit count: one gives system clock, else ext select picks.
// - In split mode each byte rollover sets that byte's overflow flag.
// - Low overflow flag, bit 6, sets on every low byte rollover.
// - Split mode interrupts on high overflow, and low if enabled.
// - Hardware never clears the overflow flags; software writes them.
// - Control bits 4 and 1 read zero and ignore writes.
// - Control register at index 0xc8, bit writable, resets to zero.
// - Reload low and high at 0xca and 0xcb, read-write, reset zero.
// - Count low and high at 0xcc and 0xcd, read-write, reset zero.
module t5ar_top
  import t5ar_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SYS_DIV = `T5AR_SYS_DIV,
  parameter int EXT_DIV = `T5AR_EXT_DIV
) (
  input wire logic clock_i,                // System clock, 20 MHz
  input wire logic resetn_i,               // Synchronous reset, active low
  input wire logic ext_clk_i,              // External oscillator input
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i,        // Write address valid
  output logic s_axi_awready_o,            // Write address ready
  input wire logic [31:0] s_axi_wdata_i,   // Write data
  input wire logic [3:0] s_axi_wstrb_i,    // Write byte strobes
  input wire logic s_axi_wvalid_i,         // Write data valid
  output logic s_axi_wready_o,             // Write data ready
  output logic [1:0] s_axi_bresp_o,        // Write response
  output logic s_axi_bvalid_o,             // Write response valid
  input wire logic s_axi_bready_i,         // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i,        // Read address valid
  output logic s_axi_arready_o,            // Read address ready
  output logic [31:0] s_axi_rdata_o,       // Read data
  output logic [1:0] s_axi_rresp_o,        // Read response
  output logic s_axi_rvalid_o,             // Read data valid
  input wire logic s_axi_rready_i,         // Read data ready
  output logic timer_irq_o                 // Interrupt request, active high
);

  // Register index from a byte address
  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W+7:0] wide;
    wide = {8'h00, a};
    return wide[11:2];
  endfunction

  // Mapped index check
  function automatic logic is_mapped(input logic [9:0] idx);
    return (idx == `T5AR_IDX_CTRL) || (idx == `T5AR_IDX_RLD_LOW) ||
           (idx == `T5AR_IDX_RLD_HIGH) || (idx == `T5AR_IDX_CNT_LOW) ||
           (idx == `T5AR_IDX_CNT_HIGH) || (idx == `T5AR_IDX_CLK_CTRL) ||
           (idx == `T5AR_IDX_IRQ_EN);
  endfunction

  // Advance one byte: wrap to reload value after all ones
  function automatic logic [7:0] bump8(input logic [7:0] v,
                                       input logic [7:0] rld,
                                       input logic do_reload);
    logic [7:0] r;
    r = v + 8'h01;
    if (do_reload) begin
      r = rld;
    end
    return r;
  endfunction

  // Register state
  t5ar_ctrl_type ctrl_r;
  t5ar_ctrl_type ctrl_nxt;
  t5ar_clk_type clk_r;
  logic [7:0] irq_en_r;
  logic [7:0] rld_low_r;
  logic [7:0] rld_high_r;
  logic [7:0] cnt_low_r;
  logic [7:0] cnt_high_r;
  logic [7:0] cnt_low_nxt;
  logic [7:0] cnt_high_nxt;

  // Bus state
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Ticks from the divider
  logic div12_tick;
  logic ext8_tick;

  t5ar_tick_gen #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .ext_clk_i(ext_clk_i),
    .div12_tick_o(div12_tick),
    .ext8_tick_o(ext8_tick)
  );

  // Write channel handshakes and commit strobe
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [9:0] wr_idx = reg_index(awaddr_r);
  wire wr_en = wr_fire & wstrb0_r & is_mapped(wr_idx);
  wire wr_ctrl = wr_en & (wr_idx == `T5AR_IDX_CTRL);
  wire wr_rld_low = wr_en & (wr_idx == `T5AR_IDX_RLD_LOW);
  wire wr_rld_high = wr_en & (wr_idx == `T5AR_IDX_RLD_HIGH);
  wire wr_cnt_low = wr_en & (wr_idx == `T5AR_IDX_CNT_LOW);
  wire wr_cnt_high = wr_en & (wr_idx == `T5AR_IDX_CNT_HIGH);
  wire wr_clk = wr_en & (wr_idx == `T5AR_IDX_CLK_CTRL);
  wire wr_irq = wr_en & (wr_idx == `T5AR_IDX_IRQ_EN);

  // Read channel handshake and decode
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire [9:0] rd_idx = reg_index(s_axi_araddr_i);
  wire [7:0] rd_byte =
    (rd_idx == `T5AR_IDX_CTRL) ? (ctrl_r & `T5AR_CTRL_WMASK) :
    (rd_idx == `T5AR_IDX_RLD_LOW) ? rld_low_r :
    (rd_idx == `T5AR_IDX_RLD_HIGH) ? rld_high_r :
    (rd_idx == `T5AR_IDX_CNT_LOW) ? cnt_low_r :
    (rd_idx == `T5AR_IDX_CNT_HIGH) ? cnt_high_r :
    (rd_idx == `T5AR_IDX_CLK_CTRL) ? clk_r :
    (rd_idx == `T5AR_IDX_IRQ_EN) ? irq_en_r : 8'h00;

  // Mode decode: split only when auxiliary bit is clear
  wire split_on = ctrl_r.split & ~clk_r.aux;
  t5ar_mode_type mode;
  assign mode = split_on ? T5AR_MODE_SPLIT : T5AR_MODE_WIDE;

  // Per-byte tick selection
  wire ext_or_div = ctrl_r.xclk ? ext8_tick : div12_tick;
  wire low_tick = clk_r.low_sel ? 1'b1 : ext_or_div;
  wire high_tick = clk_r.high_sel ? 1'b1 : ext_or_div;

  // Count enables for each mode
  wire wide_inc = (mode == T5AR_MODE_WIDE) & ctrl_r.run & low_tick;
  wire low_inc = (mode == T5AR_MODE_SPLIT) & low_tick;
  wire high_inc = (mode == T5AR_MODE_SPLIT) & ctrl_r.run & high_tick;

  // Rollover detection
  wire low_full = (cnt_low_r == 8'hff);
  wire high_full = (cnt_high_r == 8'hff);
  wire wide_roll = wide_inc & low_full & high_full;
  wire wide_carry = wide_inc & low_full;
  wire split_low_roll = low_inc & low_full;
  wire split_high_roll = high_inc & high_full;
  wire set_hflag = wide_roll | split_high_roll;
  wire set_lflag = wide_carry | split_low_roll;

  // Next count, bus write wins over counting
  always_comb begin
    cnt_low_nxt = cnt_low_r;
    cnt_high_nxt = cnt_high_r;
    if (wide_inc) begin
      cnt_low_nxt = bump8(cnt_low_r, rld_low_r, wide_roll);
      if (wide_carry) begin
        cnt_high_nxt = bump8(cnt_high_r, rld_high_r, wide_roll);
      end
    end
    if (low_inc) begin
      cnt_low_nxt = bump8(cnt_low_r, rld_low_r, low_full);
    end
    if (high_inc) begin
      cnt_high_nxt = bump8(cnt_high_r, rld_high_r, high_full);
    end
    if (wr_cnt_low) begin
      cnt_low_nxt = wbyte_r;
    end
    if (wr_cnt_high) begin
      cnt_high_nxt = wbyte_r;
    end
  end

  // Next control value; hardware set beats a software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = t5ar_ctrl_type'(wbyte_r & `T5AR_CTRL_WMASK);
    end
    if (set_hflag) begin
      ctrl_nxt.hflag = 1'b1;
    end
    if (set_lflag) begin
      ctrl_nxt.lflag = 1'b1;
    end
  end

  // Interrupt request from sticky flags and enables
  assign timer_irq_o = irq_en_r[`T5AR_BIT_HFLAG] &
    (ctrl_r.hflag | (ctrl_r.lien & ctrl_r.lflag));

  // Control and clock configuration registers
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ctrl_r <= t5ar_ctrl_type'(`T5AR_CTRL_RESET);
      clk_r <= t5ar_clk_type'(`T5AR_CLK_RESET);
      irq_en_r <= `T5AR_IRQ_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_clk) begin
        clk_r <= t5ar_clk_type'(wbyte_r & `T5AR_CLK_WMASK);
      end
      if (wr_irq) begin
        irq_en_r <= wbyte_r & `T5AR_IRQ_WMASK;
      end
    end
  end

  // Reload registers
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rld_low_r <= `T5AR_BYTE_RESET;
      rld_high_r <= `T5AR_BYTE_RESET;
    end else begin
      if (wr_rld_low) begin
        rld_low_r <= wbyte_r;
      end
      if (wr_rld_high) begin
        rld_high_r <= wbyte_r;
      end
    end
  end

  // Count bytes
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt_low_r <= `T5AR_BYTE_RESET;
      cnt_high_r <= `T5AR_BYTE_RESET;
    end else begin
      cnt_low_r <= cnt_low_nxt;
      cnt_high_r <= cnt_high_nxt;
    end
  end

  // Write channel ready while nothing is held or answered
  assign s_axi_awready_o = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready_o = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // Write address and data capture, either order
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wbyte_r <= s_axi_wdata_i[7:0];
        wstrb0_r <= s_axi_wstrb_i[0];
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `T5AR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(wr_idx) ? `T5AR_RESP_OKAY : `T5AR_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // Read data capture
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `T5AR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= is_mapped(rd_idx) ? `T5AR_RESP_OKAY : `T5AR_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ---- logic/t5ar_defines.svh ----
// Register indices, field positions, reset values and timing counts
// for the auto-reload timer. Included by the package and the modules.
`ifndef T5AR_DEFINES_SVH
`define T5AR_DEFINES_SVH

// Register indices; the byte address is four times the index
`define T5AR_IDX_CTRL 10'h0c8
`define T5AR_IDX_RLD_LOW 10'h0ca
`define T5AR_IDX_RLD_HIGH 10'h0cb
`define T5AR_IDX_CNT_LOW 10'h0cc
`define T5AR_IDX_CNT_HIGH 10'h0cd
`define T5AR_IDX_CLK_CTRL 10'h0d0
`define T5AR_IDX_IRQ_EN 10'h0d1

// Control register: writable bits, unused bits 4 and 1 stay zero
`define T5AR_CTRL_WMASK 8'hed
`define T5AR_CTRL_RESET 8'h00
`define T5AR_BIT_HFLAG 7
`define T5AR_BIT_LFLAG 6

// Clock control register: writable bits and reset
`define T5AR_CLK_WMASK 8'h07
`define T5AR_CLK_RESET 8'h00

// Interrupt enable register: only the timer enable bit is held
`define T5AR_IRQ_WMASK 8'h80
`define T5AR_IRQ_RESET 8'h00

// Byte registers reset value
`define T5AR_BYTE_RESET 8'h00

// Clock dividers
`define T5AR_SYS_DIV 12
`define T5AR_EXT_DIV 8

// AXI responses
`define T5AR_RESP_OKAY 2'b00
`define T5AR_RESP_SLVERR 2'b10

`endif

// ---- logic/t5ar_pkg.sv ----
// Types shared by the auto-reload timer modules.
// Assumes the defines header sits in the same folder.
`include "t5ar_defines.svh"

package t5ar_pkg;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic hflag;
    logic lflag;
    logic lien;
    logic unused4;
    logic split;
    logic run;
    logic unused1;
    logic xclk;
  } t5ar_ctrl_type;

  // Clock control register layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic aux;
    logic high_sel;
    logic low_sel;
  } t5ar_clk_type;

  // Counting arrangement, one-hot
  typedef enum logic [1:0] {
    T5AR_MODE_WIDE = 2'b01,
    T5AR_MODE_SPLIT = 2'b10
  } t5ar_mode_type;

endpackage

// ---- logic/t5ar_tick_gen.sv ----
// Tick generator: system clock divided by twelve, and the external
// oscillator synchronised and divided by eight. Single clock domain.
`timescale 1ns/1ps
`include "t5ar_defines.svh"

module t5ar_tick_gen #(
  parameter int SYS_DIV = `T5AR_SYS_DIV,
  parameter int EXT_DIV = `T5AR_EXT_DIV
) (
  input wire logic clock_i,   // System clock
  input wire logic resetn_i,  // Synchronous reset, active low
  input wire logic ext_clk_i, // External oscillator
  output logic div12_tick_o,  // One-cycle tick every SYS_DIV clocks
  output logic ext8_tick_o    // One-cycle tick every EXT_DIV ext edges
);

  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_r;
  logic [EW-1:0] ext_cnt_r;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic ext_edge;

  // Decoded ticks and rising edge of the synchronised oscillator
  assign ext_edge = sync2_r & ~prev_r;
  assign div12_tick_o = (sys_cnt_r == SYS_LAST);
  assign ext8_tick_o = ext_edge & (ext_cnt_r == EXT_LAST);

  // System clock prescaler
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sys_cnt_r <= '0;
    end else if (div12_tick_o) begin
      sys_cnt_r <= '0;
    end else begin
      sys_cnt_r <= sys_cnt_r + 1'b1;
    end
  end

  // Two-flop synchroniser, then edge history
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= ext_clk_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // External edge divider
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ext_cnt_r <= '0;
    end else if (ext8_tick_o) begin
      ext_cnt_r <= '0;
    end else if (ext_edge) begin
      ext_cnt_r <= ext_cnt_r + 1'b1;
    end
  end

endmodule

// ---- sim/t5ar_checker_sva.sv ----
// Port-level checker for the auto-reload timer top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module t5ar_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic clock_i,                      // Clock
  input wire logic resetn_i,                     // Reset
  input wire logic ext_clk_i,                    // Ext osc
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,  // AW addr
  input wire logic s_axi_awvalid_i,              // AW valid
  input wire logic s_axi_awready_o,              // AW ready
  input wire logic [31:0] s_axi_wdata_i,         // W data
  input wire logic [3:0] s_axi_wstrb_i,          // W strobe
  input wire logic s_axi_wvalid_i,               // W valid
  input wire logic s_axi_wready_o,               // W ready
  input wire logic [1:0] s_axi_bresp_o,          // B resp
  input wire logic s_axi_bvalid_o,               // B valid
  input wire logic s_axi_bready_i,               // B ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,  // AR addr
  input wire logic s_axi_arvalid_i,              // AR valid
  input wire logic s_axi_arready_o,              // AR ready
  input wire logic [31:0] s_axi_rdata_o,         // R data
  input wire logic [1:0] s_axi_rresp_o,          // R resp
  input wire logic s_axi_rvalid_o,               // R valid
  input wire logic s_axi_rready_i,               // R ready
  input wire logic timer_irq_o                   // Interrupt
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Bus channel relations
  wr_block_a: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write not blocked");
  rd_block_a: assert property (s_axi_rvalid_o |->
    !s_axi_arready_o) else $error("read not blocked");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write answer timing");
  b_hold_a: assert property ($fell(s_axi_bvalid_o) |->
    $past(s_axi_bready_i)) else $error("write response dropped");
  r_hold_a: assert property ($fell(s_axi_rvalid_o) |->
    $past(s_axi_rready_i)) else $error("read data dropped");
  rdata_zero_a: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h000000) else $error("upper read bits set");
  // Interrupt only drops when software writes a register
  irq_hold_a: assert property ($fell(timer_irq_o) |->
    $rose(s_axi_bvalid_o)) else $error("interrupt cleared by hardware");
  reset_idle_a: assert property (disable iff (1'b0) !resetn_i |=>
    !s_axi_bvalid_o && !s_axi_rvalid_o && !timer_irq_o && s_axi_awready_o)
    else $error("not idle after reset");
endmodule

bind t5ar_top t5ar_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .ext_clk_i(ext_clk_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
  .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .timer_irq_o(timer_irq_o));

// ---- sim/t5ar_testbench.sv ----
// Self-checking bench for the auto-reload timer over AXI4-Lite.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`include "t5ar_defines.svh"
module testbench;
  import t5ar_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic [1:0] ext_div = 2'b00;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] d;
  logic [9:0] regs [7] = '{`T5AR_IDX_CTRL, `T5AR_IDX_RLD_LOW,
    `T5AR_IDX_RLD_HIGH, `T5AR_IDX_CNT_LOW, `T5AR_IDX_CNT_HIGH,
    `T5AR_IDX_CLK_CTRL, `T5AR_IDX_IRQ_EN};
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;

  t5ar_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .ext_clk_i(ext_clk_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer_irq_o(irq));

  // Clock, external oscillator at a quarter rate, and hang guard
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ext_div <= ext_div + 2'b01;
    ext_clk_i <= ext_div[1];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Write one register; address and data released when taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] v,
                    input logic [1:0] er = `T5AR_RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge clock_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock_i);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clock_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    chk({6'h00, rs}, {6'h00, er}, "write response");
  endtask

  // Read one register; upper data bits must be zero
  task automatic rd(input logic [9:0] idx, output logic [7:0] v,
                    input logic [1:0] er = `T5AR_RESP_OKAY);
    logic ta, tr;
    logic [1:0] rs;
    logic [31:0] dw;
    @(posedge clock_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock_i);
      ta = arvalid & arready;
      tr = rvalid;
      rs = rresp;
      dw = rdata;
      @(posedge clock_i);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    v = dw[7:0];
    chk({6'h00, rs}, {6'h00, er}, "read response");
    chk(dw[31:24] | dw[23:16] | dw[15:8], 8'h00, "read upper bits");
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd(idx, v);
    chk(v, exp, "register value");
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 300) begin
      @(negedge clock_i);
      i++;
    end
    chk({7'h00, irq}, 8'h01, "interrupt request");
  endtask

  // Count ticks over n cycles from a cleared low byte
  task automatic rate(input logic [7:0] ctl, input int n, input int dv);
    logic [7:0] v;
    wr(`T5AR_IDX_CTRL, ctl);
    wr(`T5AR_IDX_CNT_LOW, 8'h00);
    repeat (n) @(posedge clock_i);
    rd(`T5AR_IDX_CNT_LOW, v);
    chk({7'h00, int'(v) >= n / dv - 1 && int'(v) <= n / dv + 5}, 8'h01,
        "tick rate");
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (regs[i]) rdc(regs[i], 8'h00);
    wr(`T5AR_IDX_RLD_LOW, 8'h5a);
    rdc(`T5AR_IDX_RLD_LOW, 8'h5a);
    wr(`T5AR_IDX_CNT_HIGH, 8'ha5);
    rdc(`T5AR_IDX_CNT_HIGH, 8'ha5);
    wr(`T5AR_IDX_CTRL, 8'h12);
    rdc(`T5AR_IDX_CTRL, 8'h00);
    wr(10'h0c9, 8'hff, `T5AR_RESP_SLVERR);
    rd(10'h0c9, d, `T5AR_RESP_SLVERR);
    chk(d, 8'h00, "unmapped read");
    // Tick sources: system clock, divided by 12, external over 8
    wr(`T5AR_IDX_CLK_CTRL, 8'h01);
    rate(8'h04, 100, 1);
    wr(`T5AR_IDX_CLK_CTRL, 8'h00);
    rate(8'h04, 600, 12);
    rate(8'h05, 640, 32);
    // 16-bit rollover reloads both bytes and sets both flags
    wr(`T5AR_IDX_CLK_CTRL, 8'h01);
    wr(`T5AR_IDX_CTRL, 8'h00);
    wr(`T5AR_IDX_RLD_LOW, 8'hcd);
    wr(`T5AR_IDX_RLD_HIGH, 8'hab);
    wr(`T5AR_IDX_CNT_HIGH, 8'hff);
    wr(`T5AR_IDX_CNT_LOW, 8'he0);
    wr(`T5AR_IDX_IRQ_EN, 8'h80);
    wr(`T5AR_IDX_CTRL, 8'h04);
    wait_irq();
    repeat (20) @(posedge clock_i);
    rdc(`T5AR_IDX_CTRL, 8'hc4);
    wr(`T5AR_IDX_CTRL, 8'h00);
    chk({7'h00, irq}, 8'h00, "interrupt after clear");
    rdc(`T5AR_IDX_CNT_HIGH, 8'hab);
    rd(`T5AR_IDX_CNT_LOW, d);
    chk({7'h00, d > 8'hcd && d < 8'hf0}, 8'h01, "reloaded low");
    rdc(`T5AR_IDX_CNT_LOW, d);
    // Low byte interrupt enable, with and without
    wr(`T5AR_IDX_CNT_HIGH, 8'h10);
    wr(`T5AR_IDX_CNT_LOW, 8'hf8);
    wr(`T5AR_IDX_CTRL, 8'h24);
    wait_irq();
    rdc(`T5AR_IDX_CTRL, 8'h64);
    rdc(`T5AR_IDX_CNT_HIGH, 8'h11);
    wr(`T5AR_IDX_CTRL, 8'h00);
    wr(`T5AR_IDX_CNT_LOW, 8'hf8);
    wr(`T5AR_IDX_CTRL, 8'h04);
    repeat (40) @(posedge clock_i);
    chk({7'h00, irq}, 8'h00, "low overflow masked");
    rdc(`T5AR_IDX_CTRL, 8'h44);
    // Split mode: low byte runs with run clear
    wr(`T5AR_IDX_CTRL, 8'h00);
    wr(`T5AR_IDX_RLD_LOW, 8'h80);
    wr(`T5AR_IDX_CNT_LOW, 8'hf0);
    wr(`T5AR_IDX_CNT_HIGH, 8'h33);
    wr(`T5AR_IDX_CTRL, 8'h28);
    wait_irq();
    rdc(`T5AR_IDX_CNT_HIGH, 8'h33);
    rd(`T5AR_IDX_CNT_LOW, d);
    chk(d & 8'h80, 8'h80, "split low reload");
    rdc(`T5AR_IDX_CTRL, 8'h68);
    // Split mode: high byte under run control
    wr(`T5AR_IDX_CLK_CTRL, 8'h03);
    wr(`T5AR_IDX_RLD_HIGH, 8'h40);
    wr(`T5AR_IDX_CNT_HIGH, 8'hf8);
    wr(`T5AR_IDX_CTRL, 8'h0c);
    wait_irq();
    rd(`T5AR_IDX_CTRL, d);
    chk(d & 8'h8c, 8'h8c, "split high flag");
    rd(`T5AR_IDX_CNT_HIGH, d);
    chk(d & 8'hc0, 8'h40, "split high reload");
    // Auxiliary bit set: split request ignored, low byte held by run
    wr(`T5AR_IDX_CLK_CTRL, 8'h05);
    wr(`T5AR_IDX_CTRL, 8'h08);
    wr(`T5AR_IDX_CNT_LOW, 8'h20);
    repeat (10) @(posedge clock_i);
    rdc(`T5AR_IDX_CNT_LOW, 8'h20);
    wr(`T5AR_IDX_CTRL, 8'h00);
    give_verdict();
  end
endmodule
